// ---- rtl/csbu_defs.vh ----
// Constants shared by the compare, skip and branch execution unit
`ifndef CSBU_DEFS_VH
`define CSBU_DEFS_VH

// ==========================================
// Operation codes
`define CSBU_OP_NONE       4'h0
`define CSBU_OP_CMP        4'h1
`define CSBU_OP_CMP_CARRY  4'h2
`define CSBU_OP_CMP_IMM    4'h3
`define CSBU_OP_SKIP_RBC   4'h4
`define CSBU_OP_SKIP_RBS   4'h5
`define CSBU_OP_SKIP_IBC   4'h6
`define CSBU_OP_SKIP_IBS   4'h7
`define CSBU_OP_BR_SET     4'h8
`define CSBU_OP_BR_CLR     4'h9
`define CSBU_OP_BR_EQ      4'hA
`define CSBU_OP_BR_NE      4'hB

// ==========================================
// Status flag positions
`define CSBU_FLAG_C        3'h0
`define CSBU_FLAG_Z        3'h1
`define CSBU_FLAG_N        3'h2
`define CSBU_FLAG_V        3'h3
`define CSBU_FLAG_S        3'h4
`define CSBU_FLAG_H        3'h5

// ==========================================
// Program counter steps and cycle counts
`define CSBU_PC_STEP_ONE   2'h1
`define CSBU_PC_STEP_SKIP1 2'h2
`define CSBU_PC_STEP_SKIP2 2'h3
`define CSBU_CYC_ONE       2'h1
`define CSBU_CYC_TWO       2'h2
`define CSBU_CYC_THREE     2'h3

`endif

// ---- rtl/csbu_cmp_flags.v ----
// Combinational subtract-and-flag logic for compare instructions
`timescale 1ns/100ps
`default_nettype none
`include "csbu_defs.vh"

module csbu_cmp_flags (
  input  wire [7:0] op_a,
  input  wire [7:0] op_b,
  input  wire       carry_in,
  input  wire       use_carry,
  input  wire       z_in,
  output reg        flag_c,
  output reg        flag_z,
  output reg        flag_n,
  output reg        flag_v,
  output reg        flag_s,
  output reg        flag_h
);
  reg [7:0] diff;
  reg       cin;

  always @* begin
    cin    = use_carry & carry_in;
    diff   = op_a - op_b - {7'h00, cin};
    flag_n = diff[7];
    flag_v = (op_a[7] & ~op_b[7] & ~diff[7]) | (~op_a[7] & op_b[7] & diff[7]);
    flag_s = diff[7] ^ flag_v;
    flag_c = (~op_a[7] & op_b[7]) | (op_b[7] & diff[7]) | (diff[7] & ~op_a[7]);
    flag_h = (~op_a[3] & op_b[3]) | (op_b[3] & diff[3]) | (diff[3] & ~op_a[3]);
    // With carry, zero only stays set across a multi-byte compare
    flag_z = use_carry ? ((diff == 8'h00) & z_in) : (diff == 8'h00);
  end
endmodule // csbu_cmp_flags

`default_nettype wire

// ---- rtl/csbu_exec.v ----
// Compare, bit-test-and-skip and conditional branch execution unit
// ==========================================
`timescale 1ns/100ps
`default_nettype none
`include "csbu_defs.vh"

module csbu_exec #(
  parameter PC_W = 16
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire            op_valid,
  input  wire [3:0]      op_code,
  input  wire [7:0]      dest_operand,
  input  wire [7:0]      source_operand_reg,
  input  wire [7:0]      imm_value,
  input  wire [7:0]      io_value,
  input  wire [2:0]      bit_sel,
  input  wire [6:0]      branch_offset,
  input  wire            next_is_two_word,
  input  wire [PC_W-1:0] pc_in,
  input  wire [7:0]      status_flags_in,
  output reg             busy,
  output reg             done,
  output reg  [PC_W-1:0] pc_out,
  output reg             pc_load,
  output reg  [7:0]      status_flags_register,
  output reg             flags_load,
  output reg  [1:0]      cycles_used
);

  // ==========================================
  // State machine
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg            state_r;
  reg            state_nxt;
  reg  [1:0]     wait_r;
  reg  [1:0]     wait_nxt;
  reg  [PC_W-1:0] pc_hold_r;
  reg  [PC_W-1:0] pc_hold_nxt;
  reg  [1:0]     cyc_nxt;

  reg            take;
  reg            tbit;
  reg  [7:0]     flags_new;
  reg  [PC_W-1:0] target;

  wire cf_c;
  wire cf_z;
  wire cf_n;
  wire cf_v;
  wire cf_s;
  wire cf_h;

  function [PC_W-1:0] csbu_rel;
    input [PC_W-1:0] base;
    input [6:0]      off;
    begin
      csbu_rel = base + {{(PC_W-7){off[6]}}, off} + {{(PC_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function csbu_bit;
    input [7:0] val;
    input [2:0] sel;
    begin
      csbu_bit = val[sel];
    end
  endfunction

  // ==========================================
  // Compare datapath
  csbu_cmp_flags u_cmp (
    .op_a      (dest_operand),
    .op_b      ((op_code == `CSBU_OP_CMP_IMM) ? imm_value : source_operand_reg),
    .carry_in  (status_flags_in[`CSBU_FLAG_C]),
    .use_carry (op_code == `CSBU_OP_CMP_CARRY),
    .z_in      (status_flags_in[`CSBU_FLAG_Z]),
    .flag_c    (cf_c),
    .flag_z    (cf_z),
    .flag_n    (cf_n),
    .flag_v    (cf_v),
    .flag_s    (cf_s),
    .flag_h    (cf_h)
  );

  always @* begin
    flags_new = status_flags_in;
    flags_new[`CSBU_FLAG_C] = cf_c;
    flags_new[`CSBU_FLAG_Z] = cf_z;
    flags_new[`CSBU_FLAG_N] = cf_n;
    flags_new[`CSBU_FLAG_V] = cf_v;
    flags_new[`CSBU_FLAG_S] = cf_s;
    flags_new[`CSBU_FLAG_H] = cf_h;
  end

  // ==========================================
  // Condition decode
  always @* begin
    take   = 1'b0;
    tbit   = 1'b0;
    target = pc_in + {{(PC_W-2){1'b0}}, `CSBU_PC_STEP_ONE};
    case (op_code)
      `CSBU_OP_SKIP_RBC: begin
        tbit = csbu_bit(source_operand_reg, bit_sel);
        take = ~tbit;
      end
      `CSBU_OP_SKIP_RBS: begin
        tbit = csbu_bit(source_operand_reg, bit_sel);
        take = tbit;
      end
      `CSBU_OP_SKIP_IBC: begin
        tbit = csbu_bit(io_value, bit_sel);
        take = ~tbit;
      end
      `CSBU_OP_SKIP_IBS: begin
        tbit = csbu_bit(io_value, bit_sel);
        take = tbit;
      end
      `CSBU_OP_BR_SET: begin
        take = csbu_bit(status_flags_in, bit_sel);
      end
      `CSBU_OP_BR_CLR: begin
        take = ~csbu_bit(status_flags_in, bit_sel);
      end
      `CSBU_OP_BR_EQ: begin
        take = status_flags_in[`CSBU_FLAG_Z];
      end
      `CSBU_OP_BR_NE: begin
        take = ~status_flags_in[`CSBU_FLAG_Z];
      end
      default: begin
        take = 1'b0;
      end
    endcase
    if (take && op_code[3]) begin
      target = csbu_rel(pc_in, branch_offset);
    end else if (take) begin
      // One extra cycle per skipped word
      target = pc_in + {{(PC_W-2){1'b0}},
                        next_is_two_word ? `CSBU_PC_STEP_SKIP2 : `CSBU_PC_STEP_SKIP1};
    end
  end

  always @* begin
    cyc_nxt = `CSBU_CYC_ONE;
    if (take && op_code[3]) begin
      cyc_nxt = `CSBU_CYC_TWO;
    end else if (take) begin
      cyc_nxt = next_is_two_word ? `CSBU_CYC_THREE : `CSBU_CYC_TWO;
    end
  end

  // ==========================================
  // Sequencing: results appear when the last cycle of the instruction ends
  always @* begin
    state_nxt   = state_r;
    wait_nxt    = wait_r;
    pc_hold_nxt = pc_hold_r;
    case (state_r)
      ST_IDLE: begin
        if (op_valid && cyc_nxt != `CSBU_CYC_ONE) begin
          state_nxt   = ST_WAIT;
          wait_nxt    = cyc_nxt - `CSBU_CYC_ONE;
          pc_hold_nxt = target;
        end
      end
      ST_WAIT: begin
        wait_nxt = wait_r - `CSBU_CYC_ONE;
        if (wait_r == `CSBU_CYC_ONE) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_r               <= ST_IDLE;
      wait_r                <= 2'h0;
      pc_hold_r             <= {PC_W{1'b0}};
      busy                  <= 1'b0;
      done                  <= 1'b0;
      pc_out                <= {PC_W{1'b0}};
      pc_load               <= 1'b0;
      status_flags_register <= 8'h00;
      flags_load            <= 1'b0;
      cycles_used           <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      wait_r     <= wait_nxt;
      pc_hold_r  <= pc_hold_nxt;
      done       <= 1'b0;
      pc_load    <= 1'b0;
      flags_load <= 1'b0;
      busy       <= (state_nxt == ST_WAIT);
      if (state_r == ST_IDLE && op_valid) begin
        cycles_used <= cyc_nxt;
        if (cyc_nxt == `CSBU_CYC_ONE) begin
          done    <= 1'b1;
          pc_load <= 1'b1;
          pc_out  <= target;
          // Compares write flags only; skips and branches leave them alone
          if (op_code == `CSBU_OP_CMP || op_code == `CSBU_OP_CMP_CARRY ||
              op_code == `CSBU_OP_CMP_IMM) begin
            status_flags_register <= flags_new;
            flags_load            <= 1'b1;
          end
        end
      end else if (state_r == ST_WAIT && wait_r == `CSBU_CYC_ONE) begin
        done    <= 1'b1;
        pc_load <= 1'b1;
        pc_out  <= pc_hold_r;
      end
    end
  end

endmodule // csbu_exec

`default_nettype wire

// ---- tb/csbu_exec_properties.sv ----
// Concurrent checks on the ports of the compare, skip and branch unit
`timescale 1ns/100ps
`default_nettype none
module csbu_exec_chk #(
  parameter PC_W = 16
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            op_valid,
  input wire logic [3:0]      op_code,
  input wire logic [7:0]      dest_operand,
  input wire logic [7:0]      source_operand_reg,
  input wire logic            busy,
  input wire logic            done,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic            pc_load,
  input wire logic [7:0]      status_flags_register,
  input wire logic            flags_load,
  input wire logic [1:0]      cycles_used
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A request is only taken while idle; busy cycles ignore op_valid
  wire take = op_valid && !busy;
  a_load_with_done: assert property (done |-> pc_load && !busy)
    else $error("pc_load or busy wrong at done");
  a_cmp_one_cycle: assert property (take && op_code inside {4'h1, 4'h2, 4'h3}
    |=> done && flags_load && cycles_used == 2'h1)
    else $error("compare not finished in one cycle");
  a_no_flag_write: assert property (take && op_code > 4'h3 |=> !flags_load)
    else $error("flags written by skip or branch");
  a_flags_only_cmp: assert property (flags_load |-> done && cycles_used == 2'h1)
    else $error("flags_load outside a compare");
  a_equal_sets_zero: assert property (take && op_code == 4'h1 && dest_operand ==
    source_operand_reg |=> status_flags_register[1] && !status_flags_register[0])
    else $error("equal compare did not set zero");
  a_busy_means_multi: assert property (take |=> busy == (cycles_used != 2'h1))
    else $error("busy does not match cycle count");
  a_taken_two_cycle: assert property (take ##1 cycles_used == 2'h2
    |-> busy ##1 (done && !busy))
    else $error("two-cycle timing wrong");
  a_skip_three_cycle: assert property (take ##1 cycles_used == 2'h3
    |-> busy [*2] ##1 done)
    else $error("three-cycle skip timing wrong");
  a_pc_holds: assert property (!pc_load |-> $stable(pc_out))
    else $error("pc_out moved without pc_load");
  a_status_holds: assert property (!flags_load |-> $stable(status_flags_register))
    else $error("flags moved without flags_load");
endmodule // csbu_exec_chk

bind csbu_exec csbu_exec_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .op_valid(op_valid), .op_code(op_code), .dest_operand(dest_operand),
  .source_operand_reg(source_operand_reg), .busy(busy), .done(done), .pc_out(pc_out),
  .pc_load(pc_load), .status_flags_register(status_flags_register),
  .flags_load(flags_load), .cycles_used(cycles_used));
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking random bench for the compare, skip and branch unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        op_valid = 1'b0;
  logic [3:0]  op_code = 4'h0;
  logic [7:0]  dst = 8'h00, src = 8'h00, imm = 8'h00, iov = 8'h00, sfi = 8'h00;
  logic [7:0]  fl = 8'h00;
  logic [2:0]  bsel = 3'h0;
  logic [6:0]  koff = 7'h00;
  logic        two_w = 1'b0;
  logic [15:0] pc = 16'h0000;
  wire         busy, done, pc_load, flags_load;
  wire  [15:0] pc_out;
  wire  [7:0]  sfr;
  wire  [1:0]  cyc;
  int          err_count = 0;
  int          n_checks = 0;

  csbu_exec #(.PC_W(16)) uut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .dest_operand(dst), .source_operand_reg(src), .imm_value(imm),
    .io_value(iov), .bit_sel(bsel), .branch_offset(koff), .next_is_two_word(two_w),
    .pc_in(pc), .status_flags_in(sfi), .busy(busy), .done(done), .pc_out(pc_out),
    .pc_load(pc_load), .status_flags_register(sfr), .flags_load(flags_load),
    .cycles_used(cyc));

  always #5 clk = ~clk;

  // ==========
  // Expectations
  function automatic logic [7:0] exp_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic wc);
    logic [8:0] r;
    logic [7:0] o;
    logic [4:0] h;
    r = {1'b0, a} - {1'b0, b} - {8'h00, wc & sfi[0]};
    // Half borrow worked out on the low nibble on its own
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, wc & sfi[0]};
    o = sfi;
    o[0] = r[8];
    o[1] = (r[7:0] == 8'h00) && (!wc || sfi[1]);
    o[2] = r[7];
    // Signed overflow: operand signs differ and the result sign left the first operand's
    o[3] = (a[7] != b[7]) && (r[7] != a[7]);
    o[4] = o[2] ^ o[3];
    o[5] = h[4];
    return o;
  endfunction

  // Returns cycle count above the next program counter
  function automatic logic [17:0] exp_res();
    logic s;
    logic t;
    s = 1'b0;
    t = 1'b0;
    case (op_code)
      4'h4: s = !src[bsel];
      4'h5: s = src[bsel];
      4'h6: s = !iov[bsel];
      4'h7: s = iov[bsel];
      4'h8: t = sfi[bsel];
      4'h9: t = !sfi[bsel];
      4'hA: t = sfi[1];
      4'hB: t = !sfi[1];
      default: ;
    endcase
    if (s) return {2'h2 + {1'b0, two_w}, pc + 16'h0002 + {15'h0000, two_w}};
    if (t) return {2'h2, pc + {{9{koff[6]}}, koff} + 16'h0001};
    return {2'h1, pc + 16'h0001};
  endfunction

  // ==========
  // Drivers and compare
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // op_valid stays high through busy cycles, which the unit must ignore
  task automatic issue();
    logic [17:0] e;
    logic        cm;
    int          n;
    e = exp_res();
    cm = op_code inside {4'h1, 4'h2, 4'h3};
    if (cm) fl = exp_flags(dst, op_code == 4'h3 ? imm : src, op_code == 4'h2);
    op_valid = 1'b1;
    n = 0;
    @(posedge clk);
    #1;
    while (done !== 1'b1 && n < 5) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("latency", 18'(e[17:16]), 18'(n + 1));
    chk("cycles_used", 18'(e[17:16]), 18'(cyc));
    chk("pc_out", 18'(e[15:0]), 18'(pc_out));
    chk("flags_load", 18'(cm), 18'(flags_load));
    chk("pc_load_busy", 18'h00002, 18'({pc_load, busy}));
    chk("flags", 18'(fl), 18'(sfr));
  endtask

  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h1303058d));
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset", 18'h00000, {busy, done, pc_out});
    chk("reset_flags", 18'h00000, 18'({pc_load, flags_load, sfr, cyc}));
    // Boundary operands, offsets at both extremes and a wrapping counter
    for (int i = 0; i < 24; i++) begin
      op_code = 4'(i % 12);
      dst = (i < 12) ? 8'h00 : 8'h80;
      src = (i < 12) ? 8'h01 : 8'h80;
      imm = dst;
      iov = src;
      sfi = (i < 12) ? 8'hFF : 8'h00;
      bsel = 3'h7;
      koff = (i < 12) ? 7'h40 : 7'h3F;
      two_w = (i >= 12);
      pc = 16'hFFFF;
      issue();
    end
    for (int i = 0; i < 600; i++) begin
      if ($urandom_range(3) == 0) begin
        op_valid = 1'b0;
        @(posedge clk);
        #1;
      end
      op_code = 4'($urandom_range(11));
      {dst, src, imm, iov} = $urandom;
      {sfi, bsel, koff, two_w} = 19'($urandom);
      pc = 16'($urandom);
      issue();
    end
    op_valid = 1'b0;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
